// [rtl/lcsc_pkg.sv]
// constants shared by the logic cell storage and control block
package lcsc_pkg;

  // index of each internal control signal in the control vector
  localparam logic [1:0] CTL_ENA = 2'h0;
  localparam logic [1:0] CTL_PCLR = 2'h1;
  localparam logic [1:0] CTL_DIN = 2'h2;
  localparam logic [1:0] CTL_TL1 = 2'h3;
  localparam int CTL_N = 4;
  localparam int CTL_SEL_W = 2;

  // storage element data sources
  localparam logic [1:0] DSEL_F = 2'h0;
  localparam logic [1:0] DSEL_G = 2'h1;
  localparam logic [1:0] DSEL_H = 2'h2;
  localparam logic [1:0] DSEL_DIN = 2'h3;

  // lookup table modes of the two four-input generators
  localparam logic [1:0] RAM_LOGIC = 2'h0;
  localparam logic [1:0] RAM_16X2 = 2'h1;
  localparam logic [1:0] RAM_32X1 = 2'h2;
  localparam logic [1:0] RAM_DUAL = 2'h3;

  // lookup table geometry
  localparam int LUT_AW = 4;
  localparam int H_TT_W = 8;

  // preset/clear value codes; reset is the default
  localparam logic INIT_RESET = 1'h0;
  localparam logic INIT_SET = 1'h1;

  // generator selects for the two function outputs
  localparam logic OSEL_FG = 1'h0;
  localparam logic OSEL_H = 1'h1;

endpackage

// [rtl/lcsc_lut_ram.sv]
// one four-input lookup table usable as a 16x1 writable memory
`timescale 1ns/1ps
module lcsc_lut_ram #(
  parameter int AW = 4
) (
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  input wire logic ce_in,
  input wire logic wr_en_in,
  input wire logic [AW-1:0] wr_addr_in,
  input wire logic wr_data_in,
  input wire logic [AW-1:0] rd_addr_in,
  output logic rd_data_out
);

  localparam int DEPTH = 1 << AW;

  // table contents, one bit per address
  logic [DEPTH-1:0] cell_ff;

  // refuse sizes the flat bit vector cannot sensibly hold
  if (AW < 1 || AW > 8) begin : bad_aw
    $error("lcsc_lut_ram: AW must lie in 1..8");
  end

  // write port; contents clear at power-up
  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      cell_ff <= '0;
    end else if (ce_in && wr_en_in) begin
      cell_ff[wr_addr_in] <= wr_data_in;
    end
  end

  // read is a plain mux, same delay as logic use
  assign rd_data_out = cell_ff[rd_addr_in];

endmodule

// [rtl/lcsc_cell.sv]
// storage and control portion of one programmable logic cell
//
// Summary of operation
// - one bit per element picks set or reset for all three sources.
// - set/reset choice and local enable are separate per element.
// - local preset/clear acts when high; no polarity option.
// - global preset/clear and power-up force the configured value.
// - local and global preset/clear drive the same configured value.
// - element data comes from F, G, H generators or direct-in.
// - each registered output can bypass to any control pin.
// - any control pin can feed any internal control signal.
// - logic mode controls: enable, preset/clear or h in 0, DIN, h in 1.
// - memory mode controls: enable, write enable, data, data or addr4.
// - generators act as RAM in 16x2, 32x1 or dual 16x1 form.
// - edge write and dual port are chosen per cell.
// - RAM read is combinational like logic; write is on the clock edge or, in level mode, while WE is high.
// - elements work as registers while generators do other work.
// - unconnected controls read low, enable reads high; reset default.
// - shared cell clock and high enable; clock invert per element.
// - flip-flop captures on active edge with enable high, else holds.
// - either element may be a latch on the same clock and enable.
`timescale 1ns/1ps
module lcsc_cell #(
  parameter int LUT_AW = lcsc_pkg::LUT_AW
) (
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  input wire logic ce_in,
  input wire logic cell_clk_in,
  input wire logic [3:0] cell_control_pins_in,
  input wire logic [3:0] ctl_connected_in,
  input wire logic [7:0] cfg_ctl_map_in,
  input wire logic [LUT_AW-1:0] f_in,
  input wire logic [LUT_AW-1:0] g_in,
  input wire logic global_preset_clear_in,
  input wire logic [1:0] cfg_init_in,
  input wire logic [1:0] cfg_sr_en_in,
  input wire logic [1:0] cfg_clk_inv_in,
  input wire logic [1:0] cfg_latch_in,
  input wire logic [1:0] cfg_dsel_a_in,
  input wire logic [1:0] cfg_dsel_b_in,
  input wire logic [1:0] cfg_byp_in,
  input wire logic [1:0] cfg_byp_pin_a_in,
  input wire logic [1:0] cfg_byp_pin_b_in,
  input wire logic cfg_h0_ext_in,
  input wire logic cfg_h2_ext_in,
  input wire logic [7:0] cfg_h_table_in,
  input wire logic cfg_xsel_in,
  input wire logic cfg_ysel_in,
  input wire logic [1:0] cfg_ram_mode_in,
  input wire logic cfg_ram_f_in,
  input wire logic cfg_ram_g_in,
  input wire logic cfg_edge_wr_in,
  input wire logic cfg_wclk_inv_in,
  input wire logic cfg_lut_wr_in,
  input wire logic cfg_lut_sel_in,
  input wire logic [LUT_AW-1:0] cfg_lut_addr_in,
  input wire logic cfg_lut_data_in,
  output logic x_out,
  output logic y_out,
  output logic reg_out_a_out,
  output logic reg_out_b_out
);

  // the control vector and config ports are laid out for four controls
  if (lcsc_pkg::CTL_N != 4 || lcsc_pkg::H_TT_W != 8) begin : bad_ctl
    $error("lcsc_cell: control and H table widths are fixed");
  end
  if (LUT_AW < 1 || LUT_AW > 8) begin : bad_aw
    $error("lcsc_cell: LUT_AW must lie in 1..8");
  end

  // pick one of the four control pins by a two-bit select
  function automatic logic pick_pin(input logic [3:0] pins,
                                    input logic [1:0] sel);
    return pins[sel];
  endfunction

  // storage element data source mux
  function automatic logic pick_data(input logic [1:0] sel,
                                     input logic f, input logic g,
                                     input logic h, input logic din);
    logic v;
    v = f;
    unique case (sel)
      lcsc_pkg::DSEL_F: v = f;
      lcsc_pkg::DSEL_G: v = g;
      lcsc_pkg::DSEL_H: v = h;
      lcsc_pkg::DSEL_DIN: v = din;
    endcase
    return v;
  endfunction

  // next value of a flip-flop or latch, ignoring preset/clear
  function automatic logic store_next(input logic q, input logic d,
                                      input logic clk_now,
                                      input logic clk_was,
                                      input logic latch,
                                      input logic en);
    logic v;
    v = q;
    if (en) begin
      if (latch) begin
        if (!clk_now) begin
          v = d;
        end
      end else if (clk_now && !clk_was) begin
        v = d;
      end
    end
    return v;
  endfunction

  // internal control signals and generator nets
  logic [3:0] ctl;
  logic ram_on;
  logic deep;
  logic dual;
  logic f_rd;
  logic g_rd;
  logic f_prime;
  logic g_prime;
  logic h_prime;
  logic tl_in0;
  logic tl_in2;
  logic [LUT_AW-1:0] g_rd_addr;
  logic [LUT_AW-1:0] g_wr_addr;
  logic wclk_now;
  logic wclk_was;
  logic wr_fire;
  logic f_wr;
  logic g_wr;
  logic f_wdat;
  logic g_wdat;
  logic [LUT_AW-1:0] f_waddr;
  logic [LUT_AW-1:0] g_waddr;
  logic pc_a;
  logic pc_b;
  logic d_a;
  logic d_b;
  logic nxt_q_a;
  logic nxt_q_b;
  logic clk_prev_ff;
  logic q_a_ff;
  logic q_b_ff;

  // pin to control routing; an unrouted enable reads high, others low
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      if (ctl_connected_in[i]) begin
        ctl[i] = pick_pin(cell_control_pins_in,
                          cfg_ctl_map_in[2*i +: 2]);
      end else begin
        ctl[i] = (2'(i) == lcsc_pkg::CTL_ENA);
      end
    end
  end

  // mode decode; in memory mode the preset/clear line is write enable
  assign ram_on = (cfg_ram_mode_in != lcsc_pkg::RAM_LOGIC);
  assign deep = (cfg_ram_mode_in == lcsc_pkg::RAM_32X1);
  assign dual = (cfg_ram_mode_in == lcsc_pkg::RAM_DUAL);

  // write clock shares the cell clock pin with its own inversion
  assign wclk_now = cell_clk_in ^ cfg_wclk_inv_in;
  assign wclk_was = clk_prev_ff ^ cfg_wclk_inv_in;

  // dual port always writes on the edge; level mode writes while WE high
  always_comb begin
    if (cfg_edge_wr_in || dual) begin
      wr_fire = ctl[lcsc_pkg::CTL_PCLR] && wclk_now && !wclk_was;
    end else begin
      wr_fire = ctl[lcsc_pkg::CTL_PCLR];
    end
  end

  // write steering per memory shape; config loading takes priority
  always_comb begin
    f_wr = 1'h0;
    g_wr = 1'h0;
    f_wdat = ctl[lcsc_pkg::CTL_DIN];
    g_wdat = ctl[lcsc_pkg::CTL_TL1];
    f_waddr = f_in;
    g_waddr = g_wr_addr;
    if (cfg_lut_wr_in) begin
      f_wr = !cfg_lut_sel_in;
      g_wr = cfg_lut_sel_in;
      f_wdat = cfg_lut_data_in;
      g_wdat = cfg_lut_data_in;
      f_waddr = cfg_lut_addr_in;
      g_waddr = cfg_lut_addr_in;
    end else if (ram_on && wr_fire) begin
      unique case (cfg_ram_mode_in)
        lcsc_pkg::RAM_16X2: begin
          f_wr = cfg_ram_f_in;
          g_wr = cfg_ram_g_in;
        end
        lcsc_pkg::RAM_32X1: begin
          // fifth address bit picks the half to write
          f_wr = !ctl[lcsc_pkg::CTL_TL1];
          g_wr = ctl[lcsc_pkg::CTL_TL1];
          g_wdat = ctl[lcsc_pkg::CTL_DIN];
        end
        lcsc_pkg::RAM_DUAL: begin
          // both tables take the same word at the F address
          f_wr = 1'h1;
          g_wr = 1'h1;
          g_wdat = ctl[lcsc_pkg::CTL_DIN];
        end
        default: begin
          f_wr = 1'h0;
          g_wr = 1'h0;
        end
      endcase
    end
  end

  // deep mode shares the F address; dual reads G at its own pins
  assign g_rd_addr = deep ? f_in : g_in;
  assign g_wr_addr = (deep || dual) ? f_in : g_in;

  // the F generator table
  lcsc_lut_ram #(
    .AW(LUT_AW)
  ) u_f_lut (
    .ref_clk_in(ref_clk_in),
    .rstn_in(rstn_in),
    .ce_in(ce_in),
    .wr_en_in(f_wr),
    .wr_addr_in(f_waddr),
    .wr_data_in(f_wdat),
    .rd_addr_in(f_in),
    .rd_data_out(f_rd)
  );

  // the G generator table
  lcsc_lut_ram #(
    .AW(LUT_AW)
  ) u_g_lut (
    .ref_clk_in(ref_clk_in),
    .rstn_in(rstn_in),
    .ce_in(ce_in),
    .wr_en_in(g_wr),
    .wr_addr_in(g_waddr),
    .wr_data_in(g_wdat),
    .rd_addr_in(g_rd_addr),
    .rd_data_out(g_rd)
  );

  // generator outputs; deep mode folds both halves onto F
  assign f_prime = (deep && ctl[lcsc_pkg::CTL_TL1]) ? g_rd : f_rd;
  assign g_prime = g_rd;

  // third generator inputs; preset/clear line is write enable in memory
  assign tl_in0 = (cfg_h0_ext_in && !ram_on) ?
                  ctl[lcsc_pkg::CTL_PCLR] : f_prime;
  assign tl_in2 = cfg_h2_ext_in ? ctl[lcsc_pkg::CTL_DIN] : g_prime;
  assign h_prime = cfg_h_table_in[{tl_in2, ctl[lcsc_pkg::CTL_TL1], tl_in0}];

  // combinational function outputs
  assign x_out = (cfg_xsel_in == lcsc_pkg::OSEL_H) ? h_prime : f_prime;
  assign y_out = (cfg_ysel_in == lcsc_pkg::OSEL_H) ? h_prime : g_prime;

  // element data; generators stay free for other work
  assign d_a = pick_data(cfg_dsel_a_in, f_prime, g_prime, h_prime,
                         ctl[lcsc_pkg::CTL_DIN]);
  assign d_b = pick_data(cfg_dsel_b_in, f_prime, g_prime, h_prime,
                         ctl[lcsc_pkg::CTL_DIN]);

  // local line only counts in logic mode and when enabled per element;
  // no inverter exists on it, a high level asserts
  assign pc_a = (cfg_sr_en_in[0] && !ram_on &&
                 ctl[lcsc_pkg::CTL_PCLR]) || global_preset_clear_in;
  assign pc_b = (cfg_sr_en_in[1] && !ram_on &&
                 ctl[lcsc_pkg::CTL_PCLR]) || global_preset_clear_in;

  // shared clock and enable, clock inverted per element
  always_comb begin
    nxt_q_a = store_next(q_a_ff, d_a,
                         cell_clk_in ^ cfg_clk_inv_in[0],
                         clk_prev_ff ^ cfg_clk_inv_in[0],
                         cfg_latch_in[0],
                         ctl[lcsc_pkg::CTL_ENA]);
    nxt_q_b = store_next(q_b_ff, d_b,
                         cell_clk_in ^ cfg_clk_inv_in[1],
                         clk_prev_ff ^ cfg_clk_inv_in[1],
                         cfg_latch_in[1],
                         ctl[lcsc_pkg::CTL_ENA]);
    // preset/clear beats clock, enable and data
    if (pc_a) begin
      nxt_q_a = cfg_init_in[0];
    end
    if (pc_b) begin
      nxt_q_b = cfg_init_in[1];
    end
  end

  // last sampled cell clock, for edge detection
  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      clk_prev_ff <= 1'h0;
    end else if (ce_in) begin
      clk_prev_ff <= cell_clk_in;
    end
  end

  // element a; power-up loads the configured value, not a constant,
  // because one bit serves power-up, global and local alike
  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      q_a_ff <= cfg_init_in[0];
    end else if (ce_in) begin
      q_a_ff <= nxt_q_a;
    end
  end

  // element b
  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      q_b_ff <= cfg_init_in[1];
    end else if (ce_in) begin
      q_b_ff <= nxt_q_b;
    end
  end

  // feed-through muxes; bypass is pure wiring so adds no delay
  assign reg_out_a_out = cfg_byp_in[0] ?
    pick_pin(cell_control_pins_in, cfg_byp_pin_a_in) : q_a_ff;
  assign reg_out_b_out = cfg_byp_in[1] ?
    pick_pin(cell_control_pins_in, cfg_byp_pin_b_in) : q_b_ff;

endmodule

// [bench/lcsc_checker.sv]
// assertion checker for the logic cell storage and control block
`timescale 1ns/1ps
module lcsc_checker (
  input logic ref_clk_in,
  input logic rstn_in,
  input logic ce_in,
  input logic cell_clk_in,
  input logic [3:0] cell_control_pins_in,
  input logic [3:0] ctl_connected_in,
  input logic [7:0] cfg_ctl_map_in,
  input logic global_preset_clear_in,
  input logic [1:0] cfg_init_in,
  input logic [1:0] cfg_sr_en_in,
  input logic [1:0] cfg_clk_inv_in,
  input logic [1:0] cfg_latch_in,
  input logic [1:0] cfg_dsel_a_in,
  input logic [1:0] cfg_byp_in,
  input logic [1:0] cfg_byp_pin_a_in,
  input logic [1:0] cfg_ram_mode_in,
  input logic reg_out_a_out,
  input logic reg_out_b_out
);
  logic cke, dd, lpc_a, pc_a, ka, qd;
  wire [3:0] cp = cell_control_pins_in;
  wire [7:0] mp = cfg_ctl_map_in;
  // unrouted enable reads high, unrouted data reads low
  assign cke = !ctl_connected_in[0] | cp[mp[1:0]];
  assign dd = ctl_connected_in[2] & cp[mp[5:4]];
  // local line only counts in logic mode, where it is not write enable
  assign lpc_a = ctl_connected_in[1] & cp[mp[3:2]] & cfg_sr_en_in[0]
    & (cfg_ram_mode_in == lcsc_pkg::RAM_LOGIC);
  assign pc_a = global_preset_clear_in | lpc_a;
  assign ka = cell_clk_in ^ cfg_clk_inv_in[0];
  assign qd = ce_in & !pc_a & cke & !cfg_byp_in[0];

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rstn_in);

  a_reset_load_a: assert property (disable iff (1'b0)
    !rstn_in && !cfg_byp_in[0] ##1 !cfg_byp_in[0]
    |-> reg_out_a_out == $past(cfg_init_in[0]))
    else $error("element a missed its reset value");
  a_local_force_a: assert property (
    ce_in && lpc_a && !cfg_byp_in[0] ##1 !cfg_byp_in[0]
    |-> reg_out_a_out == $past(cfg_init_in[0]))
    else $error("local preset/clear did not force element a");
  a_global_force_a: assert property (
    ce_in && global_preset_clear_in && !cfg_byp_in[0] ##1 !cfg_byp_in[0]
    |-> reg_out_a_out == $past(cfg_init_in[0]))
    else $error("global preset/clear did not force element a");
  a_global_force_b: assert property (
    ce_in && global_preset_clear_in && !cfg_byp_in[1] ##1 !cfg_byp_in[1]
    |-> reg_out_b_out == $past(cfg_init_in[1]))
    else $error("global preset/clear did not force element b");
  a_enable_hold_a: assert property (
    ce_in && !pc_a && !cke && !cfg_byp_in[0] ##1 !cfg_byp_in[0]
    |-> $stable(reg_out_a_out))
    else $error("element a changed with enable low");
  a_flop_capture_a: assert property (
    qd && !cfg_latch_in[0] && ka && !$past(ka) && $past(rstn_in)
    && $past(ce_in) && cfg_dsel_a_in == lcsc_pkg::DSEL_DIN
    ##1 !cfg_byp_in[0] |-> reg_out_a_out == $past(dd))
    else $error("element a missed a clock edge capture");
  a_latch_follow_a: assert property (
    qd && cfg_latch_in[0] && !ka && cfg_dsel_a_in == lcsc_pkg::DSEL_DIN
    ##1 !cfg_byp_in[0] |-> reg_out_a_out == $past(dd))
    else $error("open latch a did not follow its data");
  a_bypass_mux_a: assert property (
    cfg_byp_in[0] |-> reg_out_a_out == cp[cfg_byp_pin_a_in])
    else $error("output a bypass shows the wrong pin");
endmodule

// [bench/lcsc_user_logic.sv]
// model of the surrounding user logic feeding one cell
`timescale 1ns/1ps
module lcsc_user_logic (
  input logic pad_in,
  input logic pad_inv_in,
  input logic [3:0] pins_in,
  output logic gpc_out,
  output logic [3:0] pins_out
);
  // the one global driver: a pad, optionally inverted after its buffer
  assign gpc_out = pad_in ^ pad_inv_in;
  // routed control nets pass straight through the interconnect
  assign pins_out = pins_in;
endmodule

// [bench/tb_top.sv]
// self-checking bench for the logic cell storage and control block
`timescale 1ns/1ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin \
  n_errors++; $display("[ERR] %0t got %b exp %b", $time, a, e); end end
module tb_top;
  logic clk, rstn, ce, kclk, pad, pinv, h0x, h2x, xs, ys, rf, rg, ew;
  logic x, y, qa, qb, gpc;
  logic [1:0] init, sren, cinv, lat, dsa, dsb, byp, bpa, bpb, rmode;
  logic [3:0] pins, conn, fa, ga, cp;
  logic [7:0] map, htab;
  int n_errors = 0;
  int total_checks = 0;

  lcsc_user_logic lcsc_user_logic_i (.pad_in(pad), .pad_inv_in(pinv),
    .pins_in(pins), .gpc_out(gpc), .pins_out(cp));
  lcsc_cell lcsc_cell_i (.ref_clk_in(clk), .rstn_in(rstn), .ce_in(ce),
    .cell_clk_in(kclk), .cell_control_pins_in(cp), .ctl_connected_in(conn),
    .cfg_ctl_map_in(map), .f_in(fa), .g_in(ga),
    .global_preset_clear_in(gpc), .cfg_init_in(init), .cfg_sr_en_in(sren),
    .cfg_clk_inv_in(cinv), .cfg_latch_in(lat), .cfg_dsel_a_in(dsa),
    .cfg_dsel_b_in(dsb), .cfg_byp_in(byp), .cfg_byp_pin_a_in(bpa),
    .cfg_byp_pin_b_in(bpb), .cfg_h0_ext_in(h0x), .cfg_h2_ext_in(h2x),
    .cfg_h_table_in(htab), .cfg_xsel_in(xs), .cfg_ysel_in(ys),
    .cfg_ram_mode_in(rmode), .cfg_ram_f_in(rf), .cfg_ram_g_in(rg),
    .cfg_edge_wr_in(ew), .cfg_wclk_inv_in(1'b0), .cfg_lut_wr_in(1'b0),
    .cfg_lut_sel_in(1'b0), .cfg_lut_addr_in(4'h0), .cfg_lut_data_in(1'b0),
    .x_out(x), .y_out(y), .reg_out_a_out(qa), .reg_out_b_out(qb));

  // cell clock low then high: captures on the rising sample
  task kedge(input logic [3:0] p);
    @(posedge clk);
    pins <= p;
    kclk <= 1'b0;
    @(posedge clk);
    kclk <= 1'b1;
    @(posedge clk);
    @(negedge clk);
  endtask

  // hold pins for one sampled cycle, look once settled
  task hold(input logic [3:0] p);
    @(posedge clk);
    pins <= p;
    @(posedge clk);
    @(negedge clk);
  endtask

  task summarize();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // main sequence; pins map to enable, preset/clear, data, third input
  initial begin
    {rstn, kclk, pad, pinv, h0x, h2x, xs, ys} = 8'h00;
    {ce, rf, rg, ew} = 4'hf;
    {lat, dsb, byp, bpa, bpb, rmode} = 12'h300;
    {init, sren, cinv, dsa} = 8'h9b;
    {pins, conn, fa, ga} = 16'h0f35;
    map = 8'he4;
    htab = 8'h00;
    repeat (6) @(posedge clk);
    @(negedge clk);
    `CHK(qa, 1'b0)
    `CHK(qb, 1'b1)
    @(posedge clk);
    rstn <= 1'b1;
    kedge(4'h5);
    `CHK(qa, 1'b1)
    kedge(4'h1);
    `CHK(qa, 1'b0)
    // falling cell clock: only the inverted element b captures
    @(posedge clk);
    pins <= 4'h5;
    kclk <= 1'b0;
    @(posedge clk);
    @(negedge clk);
    `CHK({qb, qa}, 2'h2)
    kedge(4'h4);
    `CHK(qa, 1'b0)
    // local preset/clear beats a clock edge, on a only
    @(posedge clk);
    init <= 2'h0;
    kedge(4'h7);
    `CHK({qb, qa}, 2'h2)
    @(posedge clk);
    sren <= 2'h0;
    kedge(4'h7);
    `CHK(qa, 1'b1)
    // global net from the pad, once inverted, once straight
    for (int i = 1; i < 3; i++) begin
      @(posedge clk);
      init <= i[1:0];
      pad <= i[1];
      pinv <= !i[1];
      hold(4'h7);
      `CHK({qb, qa}, i[1:0])
      @(posedge clk);
      {pad, pinv} <= 2'h0;
    end
    @(posedge clk);
    byp <= 2'h3;
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      bpa <= i[1:0];
      bpb <= 2'h3 - i[1:0];
      hold(4'h1 << i);
      `CHK({qa, qb}, 2'h2)
    end
    // reversed pin map: enable on C4, data on C2
    @(posedge clk);
    byp <= 2'h0;
    map <= 8'h1b;
    kedge(4'ha);
    `CHK(qa, 1'b1)
    kedge(4'h8);
    `CHK(qa, 1'b0)
    @(posedge clk);
    map <= 8'he4;
    conn <= 4'he;
    kedge(4'h4);
    `CHK(qa, 1'b1)
    // latch a: closed while clock high, open while low
    @(posedge clk);
    conn <= 4'hf;
    lat <= 2'h1;
    hold(4'h1);
    `CHK(qa, 1'b1)
    @(posedge clk);
    kclk <= 1'b0;
    hold(4'h1);
    `CHK(qa, 1'b0)
    // 16x2 edge write to F at 3 and G at 5, then combinational reads
    @(posedge clk);
    lat <= 2'h0;
    rmode <= lcsc_pkg::RAM_16X2;
    kedge(4'he);
    `CHK({x, y}, 2'h3)
    hold(4'h0);
    `CHK({x, y}, 2'h3)
    @(posedge clk);
    fa <= 4'h4;
    @(negedge clk);
    `CHK(x, 1'b0)
    // 32x1: the fifth address bit picks the half
    @(posedge clk);
    rmode <= lcsc_pkg::RAM_32X1;
    fa <= 4'h3;
    hold(4'h0);
    `CHK(x, 1'b1)
    hold(4'h8);
    `CHK(x, 1'b0)
    // dual port: one write, second read address on G
    @(posedge clk);
    rmode <= lcsc_pkg::RAM_DUAL;
    {fa, ga} <= 8'h77;
    kedge(4'h6);
    `CHK(y, 1'b1)
    // level write with a clock that never moves
    @(posedge clk);
    rmode <= lcsc_pkg::RAM_16X2;
    ew <= 1'b0;
    fa <= 4'h9;
    hold(4'h6);
    `CHK(x, 1'b1)
    // block enable low freezes the element through a cell clock edge
    @(posedge clk);
    ce <= 1'b0;
    kedge(4'h5);
    `CHK(qa, 1'b0)
    @(posedge clk);
    ce <= 1'b1;
    kedge(4'h5);
    `CHK(qa, 1'b1)
    summarize();
  end
endmodule

bind lcsc_cell lcsc_checker lcsc_checker_i (.ref_clk_in(ref_clk_in),
  .rstn_in(rstn_in), .ce_in(ce_in), .cell_clk_in(cell_clk_in),
  .cell_control_pins_in(cell_control_pins_in),
  .ctl_connected_in(ctl_connected_in), .cfg_ctl_map_in(cfg_ctl_map_in),
  .global_preset_clear_in(global_preset_clear_in),
  .cfg_init_in(cfg_init_in), .cfg_sr_en_in(cfg_sr_en_in),
  .cfg_clk_inv_in(cfg_clk_inv_in), .cfg_latch_in(cfg_latch_in),
  .cfg_dsel_a_in(cfg_dsel_a_in), .cfg_byp_in(cfg_byp_in),
  .cfg_byp_pin_a_in(cfg_byp_pin_a_in), .cfg_ram_mode_in(cfg_ram_mode_in),
  .reg_out_a_out(reg_out_a_out), .reg_out_b_out(reg_out_b_out));
